// >>> common/muxbus_map.svh
`ifndef MUXBUS_MAP_SVH
`define MUXBUS_MAP_SVH

// ==========================================================
// Shared bus field positions
`define MB_AD_WIDTH 32
`define MB_ADDR_MSB 31
`define MB_ADDR_LSB 4
`define MB_LANE_MSB 3
`define MB_LANE_LSB 0
`define MB_IDX_MSB 3
`define MB_IDX_LSB 2

// ==========================================================
// Depths and counts
`define MB_WBUF_DEPTH 4
`define MB_BURST_WORDS 4

// ==========================================================
// Reset values
`define MB_AD_RESET 32'h0000_0000
`define MB_IDX_RESET 2'h0
`define MB_DIAG_RESET 2'h0
`define MB_LANES_ALL 4'hf

`endif

// >>> common/muxbus_pkg.sv
package muxbus_pkg;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} size_e;

	// Device sequencer, Gray along idle-addr-turn-data
	typedef enum logic [2:0] {
		BI_IDLE = 3'h0,
		BI_ADDR = 3'h1,
		BI_TURN = 3'h3,
		BI_RDATA = 3'h2,
		BI_WDATA = 3'h5
	} biu_state_e;

	// Memory end sequencer
	typedef enum logic [2:0] {
		ME_IDLE = 3'h0,
		ME_CMD = 3'h1,
		ME_RPERM = 3'h3,
		ME_RWAIT = 3'h2,
		ME_WWAIT = 3'h5
	} mem_state_e;

endpackage : muxbus_pkg

// >>> common/muxbus_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "muxbus_map.svh"

interface muxbus_if;
	logic [`MB_AD_WIDTH-1:0] dev_ad;
	logic dev_ad_oe_n;
	logic [`MB_AD_WIDTH-1:0] mem_ad;
	logic mem_ad_oe_n;
	logic [`MB_AD_WIDTH-1:0] ad;
	logic ale;
	logic rd_cyc;
	logic wr_cyc;
	logic external_drive_permit;
	logic [1:0] word_index;
	logic [1:0] diag;
	logic quad_fetch_request;
	logic mem_done;
	logic read_buffer_load;

	// Wire level of the shared bus, pulled high when nobody drives
	assign ad = !dev_ad_oe_n ? dev_ad : (!mem_ad_oe_n ? mem_ad : {`MB_AD_WIDTH{1'b1}});

	modport dev (
		output dev_ad, dev_ad_oe_n, ale, rd_cyc, wr_cyc, external_drive_permit,
		output word_index, diag, quad_fetch_request,
		input ad, mem_done, read_buffer_load
	);

	modport mem (
		output mem_ad, mem_ad_oe_n, mem_done, read_buffer_load,
		input ad, ale, rd_cyc, wr_cyc, external_drive_permit,
		input word_index, diag, quad_fetch_request
	);
endinterface : muxbus_if

`default_nettype wire

// >>> verilog/mem_end_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "muxbus_map.svh"

module mem_end_ctrl (
	input wire logic mclk_in,
	input wire logic rst_in,
	muxbus_if.mem bus,
	output logic req_valid_out,
	output logic req_write_out,
	output logic [31:0] req_addr_out,
	output logic [3:0] req_lanes_out,
	output logic [31:0] req_wdata_out,
	output logic req_burst_out,
	input wire logic ack_in,
	input wire logic [31:0] rdata_in
);
	muxbus_pkg::mem_state_e state_ff;
	logic [`MB_ADDR_MSB:`MB_ADDR_LSB] addr_ff;
	logic [1:0] idx_ff;
	logic write_ff;
	logic burst_ff;
	logic last_word;

	assign last_word = !burst_ff || (idx_ff == 2'(`MB_BURST_WORDS - 1));

	// ==========================================================
	// Transaction sequencer
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_ff <= muxbus_pkg::ME_IDLE;
			addr_ff <= '0;
			idx_ff <= `MB_IDX_RESET;
			write_ff <= 1'b0;
			burst_ff <= 1'b0;
			req_valid_out <= 1'b0;
			req_write_out <= 1'b0;
			req_addr_out <= `MB_AD_RESET;
			req_lanes_out <= 4'h0;
			req_wdata_out <= `MB_AD_RESET;
			req_burst_out <= 1'b0;
			bus.mem_ad <= `MB_AD_RESET;
			bus.mem_ad_oe_n <= 1'b1;
			bus.mem_done <= 1'b0;
			bus.read_buffer_load <= 1'b0;
		end else begin
			req_valid_out <= 1'b0;
			bus.mem_done <= 1'b0;
			bus.read_buffer_load <= 1'b0;
			bus.mem_ad_oe_n <= 1'b1;
			case (state_ff)
				muxbus_pkg::ME_IDLE: begin
					if (bus.ale) begin
						addr_ff <= bus.ad[`MB_ADDR_MSB:`MB_ADDR_LSB];
						req_lanes_out <= bus.ad[`MB_LANE_MSB:`MB_LANE_LSB];
						idx_ff <= bus.word_index;
						write_ff <= bus.wr_cyc;
						burst_ff <= bus.rd_cyc && bus.quad_fetch_request;
						state_ff <= muxbus_pkg::ME_CMD;
					end
				end
				muxbus_pkg::ME_CMD: begin
					if (write_ff) begin
						req_valid_out <= 1'b1;
						req_write_out <= 1'b1;
						req_addr_out <= {addr_ff, idx_ff, 2'h0};
						req_wdata_out <= bus.ad;
						req_burst_out <= 1'b0;
						state_ff <= muxbus_pkg::ME_WWAIT;
					end else begin
						state_ff <= muxbus_pkg::ME_RPERM;
					end
				end
				muxbus_pkg::ME_RPERM: begin
					if (bus.external_drive_permit) begin
						req_valid_out <= 1'b1;
						req_write_out <= 1'b0;
						req_addr_out <= {addr_ff, idx_ff, 2'h0};
						req_burst_out <= burst_ff;
						state_ff <= muxbus_pkg::ME_RWAIT;
					end
				end
				muxbus_pkg::ME_RWAIT: begin
					if (ack_in && bus.external_drive_permit) begin
						bus.mem_ad <= rdata_in;
						bus.mem_ad_oe_n <= 1'b0;
						bus.read_buffer_load <= 1'b1;
						if (last_word) begin
							bus.mem_done <= 1'b1;
							state_ff <= muxbus_pkg::ME_IDLE;
						end else begin
							idx_ff <= idx_ff + 2'h1;
							state_ff <= muxbus_pkg::ME_RPERM;
						end
					end
				end
				muxbus_pkg::ME_WWAIT: begin
					if (ack_in) begin
						bus.mem_done <= 1'b1;
						state_ff <= muxbus_pkg::ME_IDLE;
					end
				end
				default: begin
					state_ff <= muxbus_pkg::ME_IDLE;
				end
			endcase
		end
	end
endmodule : mem_end_ctrl

`default_nettype wire

// >>> verilog/bus_iface_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "muxbus_map.svh"

// Summary of operation
// - Address then data share one 32-bit bus
// - Info phase latched by strobe, then data
// - Address bits 31:4 on upper bus lines
// - Byte lane strobes on bus lines 3:0
// - Writes drive data from write buffer
// - Reads return one or four words
// - Word index: address, or burst count from 0
// - Upper diag high on read miss
// - Upper diag undefined for non-read cycles
// - Upper diag shows bit 3 afterwards on reads
// - Lower diag: instruction high, data low
// - Lower diag undefined on uncached reads
// - Lower diag shows bit 2 afterwards on reads
// - Address strobe high while address valid
// - Drive permit only after device releases bus
// - Permit low on writes and idle
// - Four-deep write buffer, drained at memory pace
// - Options latched at reset
// - Byte order selectable, switchable after reset
// - Data miss refill one or four words
// - Quad request on fetch misses, selected data
// - Memory signals done after processing
// - Memory strobes load with each word

module bus_iface_unit #(
	parameter int WBUF_DEPTH = `MB_WBUF_DEPTH
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	muxbus_if.dev bus,
	input wire logic store_valid_in,
	input wire logic [31:0] store_addr_in,
	input wire muxbus_pkg::size_e store_size_in,
	input wire logic [31:0] store_data_in,
	output logic store_ready_out,
	input wire logic rd_req_in,
	input wire logic [31:0] rd_addr_in,
	input wire muxbus_pkg::size_e rd_size_in,
	input wire logic rd_miss_in,
	input wire logic rd_ifetch_in,
	output logic rd_ready_out,
	output logic [4*32-1:0] rd_data_out,
	output logic [2:0] rd_words_out,
	output logic rd_done_out,
	input wire logic big_endian_strap_in,
	input wire logic quad_refill_strap_in,
	input wire logic endian_set_in,
	input wire logic endian_value_in,
	output logic big_endian_out,
	output logic quad_refill_out,
	output logic [$clog2(WBUF_DEPTH):0] wbuf_level_out
);
	localparam int PW = $clog2(WBUF_DEPTH);

	generate
		if (WBUF_DEPTH < 2 || (1 << PW) != WBUF_DEPTH) begin : g_bad_depth
			$error("WBUF_DEPTH must be a power of two of at least 2");
		end
	endgenerate

	// Lane mask for an access of given size at given byte offset
	function automatic logic [3:0] lane_mask(input logic [1:0] off, input muxbus_pkg::size_e sz,
		input logic big);
		logic [3:0] m;
		m = `MB_LANES_ALL;
		case (sz)
			muxbus_pkg::SZ_BYTE: m = 4'h1 << off;
			muxbus_pkg::SZ_HALF: m = off[1] ? 4'hc : 4'h3;
			default: m = `MB_LANES_ALL;
		endcase
		if (big) begin
			m = {m[0], m[1], m[2], m[3]};
		end
		return m;
	endfunction : lane_mask

	muxbus_pkg::biu_state_e state_ff;
	logic [29:0] wb_addr_ff [WBUF_DEPTH];
	logic [31:0] wb_data_ff [WBUF_DEPTH];
	logic [3:0] wb_lanes_ff [WBUF_DEPTH];
	logic [PW-1:0] wb_head_ff;
	logic [PW-1:0] wb_tail_ff;
	logic [PW:0] wb_cnt_ff;
	logic [31:0] rbuf_ff [`MB_BURST_WORDS];
	logic [2:0] rcnt_ff;
	logic [29:0] cur_addr_ff;
	logic cur_burst_ff;
	logic wb_push;
	logic wb_pop;
	logic start_write;
	logic start_read;
	logic rd_burst;

	// ==========================================================
	// Configuration
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			big_endian_out <= big_endian_strap_in;
			quad_refill_out <= quad_refill_strap_in;
		end else if (endian_set_in) begin
			big_endian_out <= endian_value_in;
		end
	end

	// ==========================================================
	// Write buffer
	assign store_ready_out = (wb_cnt_ff != (PW+1)'(WBUF_DEPTH));
	assign wb_push = store_valid_in && store_ready_out;
	assign wb_pop = (state_ff == muxbus_pkg::BI_WDATA) && bus.mem_done;
	assign wbuf_level_out = wb_cnt_ff;

	always_ff @(posedge mclk_in) begin
		if (wb_push) begin
			wb_addr_ff[wb_tail_ff] <= store_addr_in[31:2];
			wb_data_ff[wb_tail_ff] <= store_data_in;
			wb_lanes_ff[wb_tail_ff] <= lane_mask(store_addr_in[1:0], store_size_in, big_endian_out);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wb_head_ff <= '0;
			wb_tail_ff <= '0;
			wb_cnt_ff <= '0;
		end else begin
			if (wb_push) begin
				wb_tail_ff <= wb_tail_ff + PW'(1);
			end
			if (wb_pop) begin
				wb_head_ff <= wb_head_ff + PW'(1);
			end
			wb_cnt_ff <= wb_cnt_ff + (PW+1)'(wb_push) - (PW+1)'(wb_pop);
		end
	end

	// ==========================================================
	// Transaction sequencer and pins
	assign rd_ready_out = (state_ff == muxbus_pkg::BI_IDLE) && (wb_cnt_ff == '0);
	assign start_write = (state_ff == muxbus_pkg::BI_IDLE) && (wb_cnt_ff != '0);
	assign start_read = rd_ready_out && rd_req_in;
	assign rd_burst = rd_miss_in && (rd_ifetch_in || quad_refill_out);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_ff <= muxbus_pkg::BI_IDLE;
			cur_addr_ff <= '0;
			cur_burst_ff <= 1'b0;
			bus.dev_ad <= `MB_AD_RESET;
			bus.dev_ad_oe_n <= 1'b1;
			bus.ale <= 1'b0;
			bus.rd_cyc <= 1'b0;
			bus.wr_cyc <= 1'b0;
			bus.external_drive_permit <= 1'b0;
			bus.word_index <= `MB_IDX_RESET;
			bus.diag <= `MB_DIAG_RESET;
			bus.quad_fetch_request <= 1'b0;
		end else begin
			case (state_ff)
				muxbus_pkg::BI_IDLE: begin
					bus.external_drive_permit <= 1'b0;
					if (start_write) begin
						cur_addr_ff <= wb_addr_ff[wb_head_ff];
						bus.dev_ad <= {wb_addr_ff[wb_head_ff][29:2], wb_lanes_ff[wb_head_ff]};
						bus.dev_ad_oe_n <= 1'b0;
						bus.ale <= 1'b1;
						bus.wr_cyc <= 1'b1;
						bus.word_index <= wb_addr_ff[wb_head_ff][1:0];
						bus.diag <= `MB_DIAG_RESET;
						bus.quad_fetch_request <= 1'b0;
						state_ff <= muxbus_pkg::BI_ADDR;
					end else if (start_read) begin
						cur_addr_ff <= rd_addr_in[31:2];
						cur_burst_ff <= rd_burst;
						bus.dev_ad <= {rd_addr_in[31:4],
							lane_mask(rd_addr_in[1:0], rd_size_in, big_endian_out)};
						bus.dev_ad_oe_n <= 1'b0;
						bus.ale <= 1'b1;
						bus.rd_cyc <= 1'b1;
						bus.word_index <= rd_burst ? 2'h0 : rd_addr_in[3:2];
						bus.diag <= {rd_miss_in, rd_miss_in && rd_ifetch_in};
						bus.quad_fetch_request <= rd_burst;
						state_ff <= muxbus_pkg::BI_ADDR;
					end
				end
				muxbus_pkg::BI_ADDR: begin
					bus.ale <= 1'b0;
					if (bus.wr_cyc) begin
						bus.dev_ad <= wb_data_ff[wb_head_ff];
						state_ff <= muxbus_pkg::BI_WDATA;
					end else begin
						bus.dev_ad_oe_n <= 1'b1;
						bus.diag <= cur_addr_ff[1:0];
						state_ff <= muxbus_pkg::BI_TURN;
					end
				end
				muxbus_pkg::BI_TURN: begin
					bus.external_drive_permit <= 1'b1;
					state_ff <= muxbus_pkg::BI_RDATA;
				end
				muxbus_pkg::BI_RDATA: begin
					if (bus.read_buffer_load && cur_burst_ff) begin
						bus.word_index <= bus.word_index + 2'h1;
					end
					if (bus.mem_done) begin
						bus.external_drive_permit <= 1'b0;
						bus.rd_cyc <= 1'b0;
						bus.quad_fetch_request <= 1'b0;
						state_ff <= muxbus_pkg::BI_IDLE;
					end
				end
				muxbus_pkg::BI_WDATA: begin
					if (bus.mem_done) begin
						bus.dev_ad_oe_n <= 1'b1;
						bus.wr_cyc <= 1'b0;
						state_ff <= muxbus_pkg::BI_IDLE;
					end
				end
				default: begin
					state_ff <= muxbus_pkg::BI_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Read buffer
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rcnt_ff <= 3'h0;
			rd_words_out <= 3'h0;
			rd_done_out <= 1'b0;
		end else begin
			rd_done_out <= 1'b0;
			if (start_read) begin
				rcnt_ff <= 3'h0;
			end else if (state_ff == muxbus_pkg::BI_RDATA) begin
				if (bus.read_buffer_load) begin
					rcnt_ff <= rcnt_ff + 3'h1;
				end
				if (bus.mem_done) begin
					rd_done_out <= 1'b1;
					rd_words_out <= rcnt_ff + 3'(bus.read_buffer_load);
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (state_ff == muxbus_pkg::BI_RDATA && bus.read_buffer_load && !rcnt_ff[2]) begin
			rbuf_ff[rcnt_ff[1:0]] <= bus.ad;
		end
	end

	generate
		for (genvar i = 0; i < `MB_BURST_WORDS; i++) begin : g_rd_out
			assign rd_data_out[i*32 +: 32] = rbuf_ff[i];
		end
	endgenerate
endmodule : bus_iface_unit

`default_nettype wire

// >>> testbench/muxbus_checker.sv
`timescale 1ns/1ps
`default_nettype none

module muxbus_checker (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic dev_ad_oe_n,
	input wire logic mem_ad_oe_n,
	input wire logic ale,
	input wire logic rd_cyc,
	input wire logic wr_cyc,
	input wire logic external_drive_permit,
	input wire logic [1:0] word_index,
	input wire logic [1:0] diag,
	input wire logic quad_fetch_request,
	input wire logic mem_done,
	input wire logic read_buffer_load
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	// ==========================================================
	// Bus ownership
	chk_permit_idle: assert property (!rd_cyc |-> !external_drive_permit)
		else $error("drive permit outside a read");
	chk_no_clash: assert property (!dev_ad_oe_n |-> mem_ad_oe_n)
		else $error("both ends drive the bus");
	chk_permit_free: assert property (external_drive_permit |-> dev_ad_oe_n)
		else $error("permit while device drives");
	chk_permit_late: assert property ($rose(external_drive_permit) |-> $past(dev_ad_oe_n) && !ale)
		else $error("permit before bus release");

	// ==========================================================
	// Phases
	chk_ale_addr: assert property (ale |-> !dev_ad_oe_n && (rd_cyc ^ wr_cyc))
		else $error("strobe without address drive");
	chk_ale_pulse: assert property (ale |=> !ale)
		else $error("strobe longer than one cycle");
	chk_wr_data: assert property (ale && wr_cyc |=> !dev_ad_oe_n && !ale)
		else $error("write data not driven");
	chk_rd_diag: assert property (ale && rd_cyc && !quad_fetch_request |=> diag == $past(word_index))
		else $error("diag not address bits");
	chk_burst_zero: assert property (ale && rd_cyc && quad_fetch_request |-> word_index == 2'h0)
		else $error("burst index not zero");
	chk_burst_step: assert property (read_buffer_load && quad_fetch_request && !mem_done
		|=> word_index == $past(word_index) + 2'h1)
		else $error("burst index not stepped");
endmodule : muxbus_checker

`default_nettype wire

// >>> testbench/cpu_muxed_bus_interface_test.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_muxed_bus_interface_test;
	typedef struct packed {logic [31:0] a; logic m; logic f; logic [2:0] w;} rd_row_s;
	typedef struct packed {logic [31:0] a; muxbus_pkg::size_e sz; logic [31:0] d; logic [3:0] ln;} st_row_s;
	logic mclk_in = 1'b0, rst_in = 1'b1;
	logic store_valid_in = 1'b0, rd_req_in = 1'b0, rd_miss_in = 1'b0, rd_ifetch_in = 1'b0;
	logic [31:0] store_addr_in = 32'h0, store_data_in = 32'h0, rd_addr_in = 32'h0, rdata_in = 32'h0;
	muxbus_pkg::size_e store_size_in = muxbus_pkg::SZ_WORD;
	logic big_endian_strap_in = 1'b0, quad_refill_strap_in = 1'b0, ack_in = 1'b0;
	logic endian_set_in = 1'b0, endian_value_in = 1'b0;
	logic store_ready_out, rd_ready_out, rd_done_out, big_endian_out, quad_refill_out;
	logic [127:0] rd_data_out;
	logic [2:0] rd_words_out, wbuf_level_out;
	logic req_valid_out, req_write_out, req_burst_out;
	logic [31:0] req_addr_out, req_wdata_out, last_addr;
	logic [3:0] req_lanes_out;
	logic last_burst;
	logic [67:0] wq[$];
	int n_fail = 0, n_checks = 0, cyc = 0, n_left = 0, gap = 0, kk = 0, fire = 0;
	rd_row_s rrows[4] = '{'{32'h1000_0008, 1'b0, 1'b0, 3'h1}, '{32'h1000_0014, 1'b1, 1'b0, 3'h1},
		'{32'h1000_002c, 1'b1, 1'b1, 3'h4}, '{32'h1000_0030, 1'b0, 1'b1, 3'h1}};
	st_row_s srows[6] = '{'{32'h2000_0004, muxbus_pkg::SZ_WORD, 32'h1111_2222, 4'hf},
		'{32'h2000_0011, muxbus_pkg::SZ_BYTE, 32'h0000_3300, 4'h2},
		'{32'h2000_0022, muxbus_pkg::SZ_HALF, 32'h4444_0000, 4'hc},
		'{32'h2000_0033, muxbus_pkg::SZ_BYTE, 32'h5500_0000, 4'h8},
		'{32'h2000_0041, muxbus_pkg::SZ_BYTE, 32'h0066_0000, 4'h4},
		'{32'h2000_0052, muxbus_pkg::SZ_HALF, 32'h0000_7777, 4'h3}};

	muxbus_if bus_link();
	bus_iface_unit u_bus_iface_unit (.mclk_in, .rst_in, .bus(bus_link.dev), .store_valid_in,
		.store_addr_in, .store_size_in, .store_data_in, .store_ready_out, .rd_req_in, .rd_addr_in,
		.rd_size_in(muxbus_pkg::SZ_WORD), .rd_miss_in, .rd_ifetch_in, .rd_ready_out, .rd_data_out,
		.rd_words_out, .rd_done_out, .big_endian_strap_in, .quad_refill_strap_in, .endian_set_in,
		.endian_value_in, .big_endian_out, .quad_refill_out, .wbuf_level_out);
	mem_end_ctrl u_mem_end_ctrl (.mclk_in, .rst_in, .bus(bus_link.mem), .req_valid_out,
		.req_write_out, .req_addr_out, .req_lanes_out, .req_wdata_out, .req_burst_out, .ack_in,
		.rdata_in);
	muxbus_checker u_muxbus_checker (.mclk_in, .rst_in, .dev_ad_oe_n(bus_link.dev_ad_oe_n),
		.mem_ad_oe_n(bus_link.mem_ad_oe_n), .ale(bus_link.ale), .rd_cyc(bus_link.rd_cyc),
		.wr_cyc(bus_link.wr_cyc), .external_drive_permit(bus_link.external_drive_permit),
		.word_index(bus_link.word_index), .diag(bus_link.diag),
		.quad_fetch_request(bus_link.quad_fetch_request), .mem_done(bus_link.mem_done),
		.read_buffer_load(bus_link.read_buffer_load));

	initial begin
		forever #4 mclk_in = ~mclk_in;
	end

	// ==========================================================
	// Memory user side: one ack per request, with gaps; logs requests
	always @(posedge mclk_in) begin
		cyc++;
		fire = 0;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end else begin
			if (req_valid_out) begin
				n_left = 1;
				gap = 2;
				if (req_write_out) begin
					wq.push_back({req_addr_out, req_lanes_out, req_wdata_out});
				end else if (!req_burst_out || req_addr_out[3:2] == 2'h0) begin
					{last_addr, last_burst} = {req_addr_out, req_burst_out};
					kk = 0;
				end
			end else if (n_left > 0 && !ack_in) begin
				if (gap > 0) gap--;
				else begin
					fire = 1;
					rdata_in <= {16'ha5a5, last_addr[15:0]} + 32'(kk);
					kk++;
					n_left--;
					gap = 2;
				end
			end
			ack_in <= (fire != 0);
		end
	end

	task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : cmp

	task automatic rst(input logic qr);
		rst_in <= 1'b1;
		quad_refill_strap_in <= qr;
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(negedge mclk_in);
		cmp(quad_refill_out, qr);
		cmp({bus_link.dev_ad_oe_n, bus_link.external_drive_permit, wbuf_level_out}, 5'h10);
		@(posedge mclk_in);
	endtask : rst

	task automatic rd(input rd_row_s r);
		logic [31:0] ea;
		ea = r.a & (r.w == 3'h4 ? 32'hffff_fff0 : 32'hffff_fffc);
		rd_req_in <= 1'b1;
		{rd_addr_in, rd_miss_in, rd_ifetch_in} <= {r.a, r.m, r.f};
		do @(negedge mclk_in); while (!rd_ready_out);
		@(posedge mclk_in);
		rd_req_in <= 1'b0;
		repeat (200) begin
			@(negedge mclk_in);
			if (rd_done_out) break;
		end
		cmp(rd_words_out, r.w);
		cmp(last_burst, r.w == 3'h4);
		cmp(last_addr, ea);
		cmp(rd_data_out[31:0], {16'ha5a5, ea[15:0]});
		if (r.w == 3'h4) cmp(rd_data_out[127:96], {16'ha5a5, ea[15:0]} + 32'h3);
		$display("read %0h done", r.a);
		@(posedge mclk_in);
	endtask : rd

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	initial begin
		rst(1'b0);
		foreach (rrows[i]) rd(rrows[i]);
		rst(1'b1);
		rd('{32'h1000_0048, 1'b1, 1'b0, 3'h4});
		foreach (srows[i]) begin
			if (i == 4) begin
				store_valid_in <= 1'b0;
				endian_set_in <= 1'b1;
				endian_value_in <= 1'b1;
				@(posedge mclk_in);
				endian_set_in <= 1'b0;
			end
			store_valid_in <= 1'b1;
			store_addr_in <= srows[i].a;
			store_size_in <= srows[i].sz;
			store_data_in <= srows[i].d;
			do @(negedge mclk_in); while (!store_ready_out);
			@(posedge mclk_in);
		end
		store_valid_in <= 1'b0;
		cmp(big_endian_out, 1'b1);
		repeat (300) begin
			@(negedge mclk_in);
			if (wbuf_level_out == 3'h0 && !bus_link.wr_cyc) break;
		end
		cmp(wq.size(), 6);
		foreach (srows[i]) begin
			if (wq.size() > 0) cmp(wq.pop_front(), {srows[i].a & 32'hffff_fffc, srows[i].ln,
				srows[i].d});
		end
		$display("stores done");
		results();
	end
endmodule : cpu_muxed_bus_interface_test

`default_nettype wire
